/* File: common/pppm_pkg.sv */
package pppm_pkg;

    // Port slots, in pin order: P2, P3, P4, P5, P6, P7, P12, P13
    localparam int NUM_PORTS = 8;
    localparam int PT_P2 = 0;
    localparam int PT_P3 = 1;
    localparam int PT_P4 = 2;
    localparam int PT_P5 = 3;
    localparam int PT_P6 = 4;
    localparam int PT_P7 = 5;
    localparam int PT_P12 = 6;
    localparam int PT_P13 = 7;

    // Implemented pins per slot; port 7 has three, port 13 has two
    localparam logic [7:0][7:0] PIN_MASK = {
        8'h03, 8'hFF, 8'h07, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF
    };

    // APB map: group in paddr[7:5], slot or register in paddr[4:2]
    localparam int APB_AW = 12;
    localparam logic [2:0] GRP_LATCH = 3'h0;
    localparam logic [2:0] GRP_DIR = 3'h1;
    localparam logic [2:0] GRP_CTL = 3'h2;
    localparam logic [2:0] GRP_PIN = 3'h3;
    localparam logic [2:0] GRP_MISC = 3'h4;
    localparam logic [2:0] MISC_MEMX = 3'h0;
    localparam logic [2:0] MISC_PUL = 3'h1;
    localparam logic [2:0] MISC_PUH = 3'h2;
    localparam logic [2:0] MISC_RTPBUF = 3'h3;
    localparam logic [2:0] MISC_VBUS = 3'h4;
    localparam logic [2:0] MISC_STAT = 3'h5;
    localparam logic [2:0] MISC_MASK = 3'h6;

    // Field positions
    localparam int MEMX_EN_BIT = 0;
    localparam int MEMX_WAIT_BIT = 1;
    localparam int MEMX_P4IN_BIT = 2;
    localparam int STAT_KRF_BIT = 0;
    localparam int SCK_B_BIT = 2;
    localparam int SCK_A_BIT = 7;
    localparam int RD_BIT = 4;
    localparam int WR_BIT = 5;
    localparam int WAIT_BIT = 6;
    localparam int LATCH_STROBE_BIT = 7;
    localparam int VBUS_TX_BIT = 4;
    localparam int VBUS_RX_BIT = 5;
    localparam logic [7:0] P6_OD_MASK = 8'h0F;

    // Values after reset
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] MEMX_RESET = 8'h04;
    localparam logic [7:0] PU_RESET = 8'h00;
    localparam logic [7:0] RTP_RESET = 8'h00;
    localparam logic [7:0] SYNC_RESET = 8'h00;

    // Pad drive for one 8-pin port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pppm_pad_t;

    // Peripheral drive offered to one port in control mode
    typedef struct packed {
        logic [7:0] value;
        logic [7:0] enable;
    } pppm_ctl_t;

    // External memory expansion bus from the bus unit
    typedef struct packed {
        logic [7:0] adOut;
        logic adOe;
        logic [7:0] addrHigh;
        logic rdN;
        logic wrN;
        logic addrLatch;
    } pppm_mem_t;

endpackage

/* File: design/pppm_pin_sync.sv */
`timescale 1ns/1ps
module pppm_pin_sync
    import pppm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Pins and results
    input wire logic [7:0] pinIn,
    output logic [7:0] level,
    output logic [7:0] fall
);

    logic [7:0] meta_q;
    logic [7:0] sync_q;
    logic [7:0] prev_q;

    // Two stages before use; only the second stage feeds the edge detector
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta_q <= SYNC_RESET;
            sync_q <= SYNC_RESET;
            prev_q <= SYNC_RESET;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Level and one-cycle falling-edge pulse
    assign level = sync_q;
    assign fall = prev_q & ~sync_q;

endmodule

/* File: design/pppm_port_mux.sv */
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Port 2 direction chosen per bit
// [RULE2] Port 2 control mode carries serial functions
// [RULE3] Serial clock out needs direction 0, latch 1
// [RULE4] Port 3 control mode carries timer, clock, buzzer
// [RULE5] Port 4 direction set for all eight together
// [RULE6] Port 4 falling edge sets key flag
// [RULE7] Memory mode: port 4 is address/data, no pull-ups
// [RULE8] Memory mode: port 5 high address, no pull-ups
// [RULE9] Memory mode: port 6 upper pins are strobes
// [RULE10] Port 6 low pins open drain, no pull-up; in control mode the code drives them push-pull from ctlIn
// [RULE11] Unused wait pin stays an ordinary port bit
// [RULE12] Port 7 three bits, serial functions in control
// [RULE13] Pull-ups by low/high option registers, inputs only
// [RULE14] Port 12 real-time outputs update on trigger
// [RULE15] Vehicle bus pins on port 12 drop pull-ups
// [RULE16] Unused converter pin parked by software
// [RULE17] Low system reset input resets the block
// [RULE18] All multiplexed pins are inputs after reset
// [RULE19] Control mode overrides port latch and direction
module pppm_port_mux
    import pppm_pkg::*;
(
    // Clock and resets
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic sysResetN,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pads
    input wire logic [NUM_PORTS-1:0][7:0] pinIn,
    output pppm_pad_t [NUM_PORTS-1:0] pad,
    // Peripheral side
    input wire pppm_ctl_t [NUM_PORTS-1:0] ctlIn,
    input wire pppm_mem_t memBus,
    input wire logic rtpTrigger,
    output logic [NUM_PORTS-1:0][7:0] pinLevel,
    // Interrupt
    output logic irq
);

    logic rstnMeta_q;
    logic rstnSync_q;
    logic rstAll;
    logic [NUM_PORTS-1:0][7:0] latch_q;
    logic [NUM_PORTS-1:0][7:0] dir_q;
    logic [NUM_PORTS-1:0][7:0] ctl_q;
    logic [7:0] memx_q;
    logic [7:0] puL_q;
    logic [7:0] puH_q;
    logic [7:0] rtpBuf_q;
    logic [7:0] rtpOut_q;
    logic vbusSel_q;
    logic [7:0] stat_q;
    logic [7:0] mask_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    pppm_pad_t [NUM_PORTS-1:0] pad_d;
    pppm_pad_t [NUM_PORTS-1:0] pad_q;
    logic [NUM_PORTS-1:0][7:0] fallAll;
    logic [7:0] stat_d;

    // Pin reset is asynchronous to us, so it passes two stages first
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rstnMeta_q <= 1'b0;
            rstnSync_q <= 1'b0;
        end else begin
            rstnMeta_q <= sysResetN;
            rstnSync_q <= rstnMeta_q;
        end
    end
    assign rstAll = srst | ~rstnSync_q; // [RULE17]

    // APB decode
    wire [2:0] grp = paddr[7:5];
    wire [2:0] idx = paddr[4:2];
    wire aligned = (paddr[1:0] == 2'b00) && (paddr[APB_AW-1:8] == '0);
    wire slotHit = aligned && (grp <= GRP_PIN);
    wire miscHit = aligned && (grp == GRP_MISC) && (idx <= MISC_MASK);
    wire hit = slotHit | miscHit;
    wire access = psel & penable & pready_q;
    wire wrEn = access & pwrite & hit;
    wire rdEn = access & ~pwrite & hit;
    wire [7:0] wByte = pwdata[7:0];
    wire wrMisc = wrEn & (grp == GRP_MISC);

    // Read data selection
    wire [7:0] slotRead =
        (grp == GRP_LATCH) ? latch_q[idx] :
        (grp == GRP_DIR) ? dir_q[idx] :
        (grp == GRP_CTL) ? ctl_q[idx] : pinLevel[idx];
    wire [7:0] miscRead =
        (idx == MISC_MEMX) ? memx_q :
        (idx == MISC_PUL) ? puL_q :
        (idx == MISC_PUH) ? puH_q :
        (idx == MISC_RTPBUF) ? rtpBuf_q :
        (idx == MISC_VBUS) ? {7'h00, vbusSel_q} :
        (idx == MISC_STAT) ? stat_q : mask_q;
    wire [7:0] readVal = slotHit ? slotRead : (miscHit ? miscRead : 8'h00);

    // One wait state: answer registered in the first access cycle
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel & penable & ~pready_q;
            prdata_q <= {24'h000000, readVal};
            pslverr_q <= psel & penable & ~pready_q & ~hit;
        end
    end

    // Per-port slot registers; port 4 direction lives in memx instead
    genvar p;
    for (p = 0; p < NUM_PORTS; p++) begin : g_slot
        wire wrSlot = wrEn & (idx == 3'(p));
        wire [7:0] dirRst = (p == PT_P4) ? 8'h00 : DIR_RESET & PIN_MASK[p];
        always_ff @(posedge clk_sys) begin
            if (rstAll) begin
                latch_q[p] <= LATCH_RESET;
                dir_q[p] <= dirRst; // [RULE18]
                ctl_q[p] <= CTL_RESET;
            end else begin
                if (wrSlot && grp == GRP_LATCH)
                    latch_q[p] <= wByte & PIN_MASK[p];
                if (wrSlot && grp == GRP_DIR && p != PT_P4)
                    dir_q[p] <= wByte & PIN_MASK[p]; // [RULE1] [RULE12]
                if (wrSlot && grp == GRP_CTL && p != PT_P4)
                    ctl_q[p] <= wByte & PIN_MASK[p];
            end
        end
        pppm_pin_sync u_sync (
            .clk_sys(clk_sys),
            .rst(rstAll),
            .pinIn(pinIn[p] & PIN_MASK[p]),
            .level(pinLevel[p]),
            .fall(fallAll[p])
        );
    end

    // Mode and option registers
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            memx_q <= MEMX_RESET;
            puL_q <= PU_RESET;
            puH_q <= PU_RESET;
            rtpBuf_q <= RTP_RESET;
            vbusSel_q <= 1'b0;
            mask_q <= 8'h00;
        end else if (wrMisc) begin
            if (idx == MISC_MEMX) memx_q <= wByte;
            if (idx == MISC_PUL) puL_q <= wByte;
            if (idx == MISC_PUH) puH_q <= wByte;
            if (idx == MISC_RTPBUF) rtpBuf_q <= wByte;
            if (idx == MISC_VBUS) vbusSel_q <= wByte[0];
            if (idx == MISC_MASK) mask_q <= wByte;
        end
    end

    // Real-time port copies its buffer only on the trigger pulse
    always_ff @(posedge clk_sys) begin
        if (rstAll)
            rtpOut_q <= RTP_RESET;
        else if (rtpTrigger)
            rtpOut_q <= rtpBuf_q; // [RULE14]
    end

    // Sticky key flag; a new edge beats a clearing read
    wire keyFall = |fallAll[PT_P4];
    wire statRead = rdEn & (grp == GRP_MISC) & (idx == MISC_STAT);
    always_comb begin
        stat_d = statRead ? 8'h00 : stat_q;
        if (keyFall)
            stat_d[STAT_KRF_BIT] = 1'b1; // [RULE6]
    end
    always_ff @(posedge clk_sys) begin
        if (rstAll) begin
            stat_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            stat_q <= stat_d;
            irq_q <= |(stat_d & mask_q);
        end
    end

    // Mode bits
    wire memEn = memx_q[MEMX_EN_BIT];
    wire waitEn = memx_q[MEMX_WAIT_BIT];
    wire p4In = memx_q[MEMX_P4IN_BIT];

    // Pin owners: memory bus first, then control mode, then the latch
    for (p = 0; p < NUM_PORTS; p++) begin : g_pad
        logic [7:0] dirEff;
        logic [7:0] baseOut;
        logic [7:0] baseOe;
        logic [7:0] sel;
        logic [7:0] ctlVal;
        logic [7:0] ctlOe;
        logic [7:0] memOwn;
        logic [7:0] memOut;
        logic [7:0] memOe;
        logic [7:0] puDis;
        logic [7:0] puEn;
        logic [7:0] oeMix;
        logic [7:0] outMix;
        // Option bit index kept in range on both sides of the select
        localparam int PU_BIT = (p >= PT_P12) ? p - PT_P12 : p;
        if (p == PT_P4) begin : g_p4
            assign dirEff = p4In ? 8'hFF : 8'h00; // [RULE5]
            assign memOwn = {8{memEn}}; // [RULE7]
            assign memOut = memBus.adOut;
            assign memOe = {8{memBus.adOe}};
        end else if (p == PT_P5) begin : g_p5
            assign dirEff = dir_q[p];
            assign memOwn = {8{memEn}}; // [RULE8]
            assign memOut = memBus.addrHigh;
            assign memOe = 8'hFF;
        end else if (p == PT_P6) begin : g_p6
            assign dirEff = dir_q[p];
            // Wait pin is only taken when external wait is enabled
            assign memOwn = memEn ? {1'b1, waitEn, 2'b11, 4'h0}
                                  : 8'h00; // [RULE9] [RULE11]
            assign memOut = {memBus.addrLatch, 1'b0, memBus.wrN, memBus.rdN,
                             4'h0};
            assign memOe = {2'b10, 2'b11, 4'h0};
        end else begin : g_nomem
            assign dirEff = dir_q[p];
            assign memOwn = 8'h00;
            assign memOut = 8'h00;
            assign memOe = 8'h00;
        end
        if (p == PT_P6) begin : g_od
            // Low pins only sink; a 1 in the latch releases the pin
            assign baseOut = latch_q[p] & ~P6_OD_MASK; // [RULE10]
            assign baseOe = ~dirEff & ~(latch_q[p] & P6_OD_MASK);
        end else begin : g_pp
            assign baseOut = latch_q[p];
            assign baseOe = ~dirEff & PIN_MASK[p];
        end
        if (p == PT_P2) begin : g_ctl2
            // Clock pins keep direction and latch as their gate
            assign ctlVal = ctlIn[p].value &
                (latch_q[p] | ~8'h84); // [RULE2] [RULE3]
            assign ctlOe = {~dirEff[SCK_A_BIT], ctlIn[p].enable[6:3],
                            ~dirEff[SCK_B_BIT], ctlIn[p].enable[1:0]};
            assign sel = ctl_q[p];
        end else if (p == PT_P12) begin : g_ctl12
            assign sel = ctl_q[p] |
                (vbusSel_q ? 8'h30 : 8'h00); // [RULE15]
            assign ctlVal = vbusSel_q ?
                {rtpOut_q[7:6], 1'b0, ctlIn[p].value[VBUS_TX_BIT],
                 rtpOut_q[3:0]} : rtpOut_q; // [RULE14]
            assign ctlOe = vbusSel_q ? 8'hDF : 8'hFF;
        end else if (p == PT_P13) begin : g_ctl13
            // Converter output is analog; digital driver stays off
            assign sel = ctl_q[p];
            assign ctlVal = 8'h00;
            assign ctlOe = 8'h00;
        end else begin : g_ctlx
            assign sel = ctl_q[p]; // [RULE4] [RULE12]
            assign ctlVal = ctlIn[p].value;
            assign ctlOe = ctlIn[p].enable;
        end
        assign puDis = memOwn | ((p == PT_P12) ? sel & 8'h30 : 8'h00) |
            ((p == PT_P13) ? sel : 8'h00) |
            ((p == PT_P6) ? P6_OD_MASK : 8'h00);
        assign puEn = (p >= PT_P12) ? {8{puH_q[PU_BIT]}}
                                    : {8{puL_q[PU_BIT]}};
        assign outMix = (memOwn & memOut) | (~memOwn & ((sel & ctlVal) |
            (~sel & baseOut))); // [RULE19]
        assign oeMix = (memOwn & memOe) | (~memOwn & ((sel & ctlOe) |
            (~sel & baseOe)));
        assign pad_d[p].out = outMix & PIN_MASK[p];
        assign pad_d[p].oe = oeMix & PIN_MASK[p];
        assign pad_d[p].pu = puEn & ~oeMix & ~puDis & PIN_MASK[p]; // [RULE13]
    end

    // Pads are registered so every output comes from a flip-flop
    always_ff @(posedge clk_sys) begin
        if (rstAll)
            pad_q <= '0; // [RULE18]
        else
            pad_q <= pad_d;
    end

    assign pad = pad_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign irq = irq_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rstAll);

    sequence s_dirWrite;
        wrEn && grp == GRP_DIR && idx == 3'(PT_P2);
    endsequence
    property p_rule1;
        s_dirWrite |=> dir_q[PT_P2] == $past(pwdata[7:0]);
    endproperty
    a_rule1: assert property (p_rule1) else $error("p2 dir"); // [RULE1]
    property p_rule2;
        ctl_q[PT_P2][0] |=> pad[PT_P2].out[0] == $past(ctlIn[PT_P2].value[0]);
    endproperty
    a_rule2: assert property (p_rule2) else $error("p2 ctl"); // [RULE2]
    property p_rule3;
        ctl_q[PT_P2][SCK_A_BIT] && !memEn |=> pad[PT_P2].oe[SCK_A_BIT] ==
            !$past(dir_q[PT_P2][SCK_A_BIT]);
    endproperty
    a_rule3: assert property (p_rule3) else $error("sck oe"); // [RULE3]
    property p_rule4;
        ctl_q[PT_P3][3] |=> pad[PT_P3].oe[3] == $past(ctlIn[PT_P3].enable[3]);
    endproperty
    a_rule4: assert property (p_rule4) else $error("p3 ctl"); // [RULE4]
    property p_rule5;
        !memEn |=> pad[PT_P4].oe == 8'h00 || pad[PT_P4].oe == 8'hFF;
    endproperty
    a_rule5: assert property (p_rule5) else $error("p4 dir"); // [RULE5]
    property p_rule6;
        keyFall |=> stat_q[STAT_KRF_BIT] ##1
            (stat_q[STAT_KRF_BIT] || statRead);
    endproperty
    a_rule6: assert property (p_rule6) else $error("key flag"); // [RULE6]
    property p_rule7;
        memEn |=> pad[PT_P4].pu == 8'h00 &&
            pad[PT_P4].out == $past(memBus.adOut);
    endproperty
    a_rule7: assert property (p_rule7) else $error("p4 mem"); // [RULE7]
    property p_rule8;
        memEn |=> pad[PT_P5].oe == 8'hFF && pad[PT_P5].pu == 8'h00;
    endproperty
    a_rule8: assert property (p_rule8) else $error("p5 mem"); // [RULE8]
    property p_rule9;
        memEn |=> pad[PT_P6].out[RD_BIT] == $past(memBus.rdN) &&
            pad[PT_P6].oe[LATCH_STROBE_BIT] && !pad[PT_P6].pu[WR_BIT];
    endproperty
    a_rule9: assert property (p_rule9) else $error("p6 mem"); // [RULE9]
    property p_rule10;
        pad[PT_P6].pu[3:0] == 4'h0 && pad[PT_P6].out[3:0] == 4'h0;
    endproperty
    a_rule10: assert property (p_rule10) else $error("p6 od"); // [RULE10]
    property p_rule11;
        memEn && !waitEn && !ctl_q[PT_P6][WAIT_BIT] |=>
            pad[PT_P6].oe[WAIT_BIT] == !$past(dir_q[PT_P6][WAIT_BIT]);
    endproperty
    a_rule11: assert property (p_rule11) else $error("wait pin"); // [RULE11]
    property p_rule12;
        pad[PT_P7].oe[7:3] == 5'h00 && pad[PT_P7].pu[7:3] == 5'h00;
    endproperty
    a_rule12: assert property (p_rule12) else $error("p7 width"); // [RULE12]
    property p_rule13;
        !puL_q[PT_P3] |=> pad[PT_P3].pu == 8'h00 &&
            (pad[PT_P3].pu & pad[PT_P3].oe) == 8'h00;
    endproperty
    a_rule13: assert property (p_rule13) else $error("pull-up"); // [RULE13]
    property p_rule14;
        rtpTrigger |=> rtpOut_q == $past(rtpBuf_q);
    endproperty
    a_rule14: assert property (p_rule14) else $error("rtp"); // [RULE14]
    property p_rule15;
        vbusSel_q |=> pad[PT_P12].pu[VBUS_RX_BIT:VBUS_TX_BIT] == 2'b00;
    endproperty
    a_rule15: assert property (p_rule15) else $error("vbus pu"); // [RULE15]
    property p_rule17;
        disable iff (1'b0) !sysResetN [*3] |=> !memEn && !irq;
    endproperty
    a_rule17: assert property (p_rule17) else $error("reset pin"); // [RULE17]
    property p_rule18;
        disable iff (1'b0) rstAll |=> pad[PT_P2].oe == 8'h00 &&
            pad[PT_P12].oe == 8'h00 && dir_q[PT_P5] == DIR_RESET;
    endproperty
    a_rule18: assert property (p_rule18) else $error("reset dir"); // [RULE18]
    property p_rule19;
        ctl_q[PT_P3][0] |=> pad[PT_P3].out[0] == $past(ctlIn[PT_P3].value[0]);
    endproperty
    a_rule19: assert property (p_rule19) else $error("ctl prio"); // [RULE19]

endmodule

/* File: dv/pppm_periph_model.sv */
`timescale 1ns/1ps
module pppm_periph_model
    import pppm_pkg::*;
(
    // Clock
    input wire logic clk_sys,
    // Bench controls
    input wire logic [7:0] pattern,
    input wire logic trigReq,
    // Peripheral drive
    output pppm_ctl_t [NUM_PORTS-1:0] ctlIn,
    output pppm_mem_t memBus,
    output logic rtpTrigger
);
    logic reqQ = 1'b0;

    // Every peripheral offers the pattern on all eight bits but enables its low nibble only, so the
    // disabled high nibble shows whether enables are honoured
    always_comb begin
        for (int n = 0; n < NUM_PORTS; n++) begin
            ctlIn[n].value = pattern;
            ctlIn[n].enable = 8'h0F;
        end
    end

    // Bus unit: read active, write idle, latch strobe high
    assign memBus = '{adOut: pattern, adOe: 1'b1, addrHigh: ~pattern,
                      rdN: 1'b0, wrN: 1'b1, addrLatch: 1'b1};

    // Trigger is a single pulse per request, never a level
    always @(posedge clk_sys) reqQ <= trigReq;
    assign rtpTrigger = trigReq & ~reqQ;
endmodule

/* File: dv/port_pin_function_mux_bench.sv */
`timescale 1ns/1ps
module port_pin_function_mux_bench;
    import pppm_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic sysResetN = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [APB_AW-1:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic rtpTrigger;
    logic trigReq = 1'b0;
    logic [7:0] pat = 8'h00;
    logic [NUM_PORTS-1:0][7:0] pinIn = '1;
    logic [NUM_PORTS-1:0][7:0] pinLevel;
    pppm_pad_t [NUM_PORTS-1:0] pad;
    pppm_ctl_t [NUM_PORTS-1:0] ctlIn;
    pppm_mem_t memBus;
    int num_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    pppm_port_mux DUT (.clk_sys(clk_sys), .srst(srst),
        .sysResetN(sysResetN), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pad(pad),
        .ctlIn(ctlIn), .memBus(memBus), .rtpTrigger(rtpTrigger),
        .pinLevel(pinLevel), .irq(irq));
    pppm_periph_model MODEL (.clk_sys(clk_sys), .pattern(pat),
        .trigReq(trigReq), .ctlIn(ctlIn), .memBus(memBus),
        .rtpTrigger(rtpTrigger));

    // Clock, and a ceiling far above the few hundred cycles needed
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        forever begin
            @(posedge clk_sys);
            cyc++;
            if (cyc > 20000) begin
                num_errors++;
                give_verdict;
            end
        end
    end

    task automatic give_verdict;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string s, input logic [31:0] x,
                       input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", s, x, g);
        end
    endtask

    // Pad compare on {out, oe, pu}; mask hides bits left open by design
    task automatic pchk(input int s, input logic [23:0] x,
                        input logic [23:0] m);
        chk($sformatf("pad%0d", s), {8'h00, x & m}, {8'h00, pad[s] & m});
    endtask

    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // APB master; request held until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask

    task automatic rd(input string s, input logic [11:0] a,
                      input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(s, {24'h0, x}, r);
    endtask

    function automatic logic [11:0] la(input int s);
        return 12'(4 * s);
    endfunction
    function automatic logic [11:0] da(input int s);
        return 12'(32 + 4 * s);
    endfunction
    function automatic logic [11:0] ca(input int s);
        return 12'(64 + 4 * s);
    endfunction

    task automatic t_reset;
        for (int s = 0; s < NUM_PORTS; s++)
            pchk(s, 24'h0, 24'hFFFFFF);
        rd("dirP2", da(PT_P2), DIR_RESET);
        rd("memx", 12'h080, MEMX_RESET);
        chk("irq", 32'h0, {31'h0, irq});
    endtask

    task automatic t_port;
        wr(12'h084, 8'h3F);
        wr(la(PT_P2), 8'hFF);
        wr(da(PT_P2), 8'h0F);
        wr(la(PT_P7), 8'hFF);
        wr(da(PT_P7), 8'h00);
        wr(12'h080, 8'h00);
        wr(la(PT_P4), 8'h3C);
        cy(3);
        pchk(PT_P2, 24'hF0F00F, 24'hF0FFFF);
        pchk(PT_P7, 24'h070700, 24'hFFFFFF);
        pchk(PT_P4, 24'h3CFF00, 24'hFFFFFF);
        wr(12'h080, 8'h04);
    endtask

    task automatic t_ctl;
        pat <= 8'h5A;
        wr(la(PT_P3), 8'h00);
        wr(ca(PT_P3), 8'hFF);
        wr(ca(PT_P2), 8'h80);
        wr(la(PT_P2), 8'h80);
        wr(da(PT_P2), 8'h7F);
        cy(3);
        pchk(PT_P3, 24'h0A0F00, 24'h0FFF00);
        pat <= 8'h80;
        cy(3);
        pchk(PT_P2, 24'h808000, 24'h808000);
        pat <= 8'h00;
        cy(3);
        pchk(PT_P2, 24'h008000, 24'h808000);
    endtask

    // Memory mode with wait unused, so pin 6 of port 6 stays a port bit
    task automatic t_mem;
        pat <= 8'h5A;
        wr(da(PT_P6), 8'hBF);
        wr(la(PT_P6), 8'h40);
        wr(12'h080, 8'h01);
        cy(3);
        pchk(PT_P4, 24'h5AFF00, 24'hFFFFFF);
        pchk(PT_P5, 24'hA5FF00, 24'hFFFFFF);
        pchk(PT_P6, 24'hE0F000, 24'hF0FFFF);
        // External wait on: pin 6 becomes the bus unit's wait input
        wr(12'h080, 8'h03);
        cy(3);
        pchk(PT_P6, 24'hA0B000, 24'hF0FFFF);
        wr(12'h080, 8'h04);
        wr(da(PT_P6), 8'h00);
        wr(la(PT_P6), 8'h05);
        cy(3);
        pchk(PT_P6, 24'h00FA00, 24'hF0FFFF);
        wr(da(PT_P6), 8'hFF);
        cy(3);
        pchk(PT_P6, 24'h0000F0, 24'h0000FF);
    endtask

    task automatic t_p12;
        wr(12'h088, 8'h03);
        wr(12'h090, 8'h01);
        cy(3);
        pchk(PT_P12, 24'h0000CF, 24'h0000FF);
        wr(12'h090, 8'h00);
        wr(12'h08C, 8'h3C);
        wr(ca(PT_P12), 8'hFF);
        cy(3);
        pchk(PT_P12, 24'h000000, 24'hFF0000);
        trigReq <= 1'b1;
        cy(1);
        trigReq <= 1'b0;
        cy(3);
        pchk(PT_P12, 24'h3C0000, 24'hFF0000);
        // Spare converter pin parked as a low output
        wr(ca(PT_P13), 8'h01);
        wr(la(PT_P13), 8'h00);
        wr(da(PT_P13), 8'h01);
        cy(3);
        pchk(PT_P13, 24'h000200, 24'hFFFFFF);
    endtask

    task automatic t_key;
        logic [31:0] r;
        logic e;
        wr(12'h098, 8'h01);
        chk("irq", 32'h0, {31'h0, irq});
        pinIn[PT_P4] <= 8'hFE;
        cy(4);
        chk("irq", 32'h1, {31'h0, irq});
        rd("stat", 12'h094, 8'h01);
        cy(2);
        chk("irq", 32'h0, {31'h0, irq});
        rd("stat", 12'h094, 8'h00);
        rd("pinP4", 12'h068, 8'hFE);
        chk("pinLevel", 32'hFE, {24'h0, pinLevel[PT_P4]});
        pinIn[PT_P4] <= 8'hFF;
        // Unmapped group answers with an error and zero data
        apb(1'b0, 12'h0A0, 32'h0, r, e);
        chk("pslverr", 32'h1, {31'h0, e});
        chk("prdata", 32'h0, r);
    endtask

    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        t_reset;
        t_port;
        t_ctl;
        t_mem;
        t_p12;
        t_key;
        // Pin reset must undo all of the setup above
        sysResetN <= 1'b0;
        cy(4);
        sysResetN <= 1'b1;
        cy(3);
        t_reset;
        give_verdict;
    end
endmodule
